/* hw/smbus_pointer_block_read.v */
/*
 * Serial slave: pointer, send byte, block read, block write, reboot and
 * power-up configuration copy from configuration EEPROM to volatile latches.
 * Assumes scl/sda pins arrive asynchronously; memory storage sits outside,
 * reached by a simple one-cycle read port and write strobe.
 */
// How it works
// RULE1 - command C1h after write address starts a block read
// RULE2 - master repeats START and sends address with read bit
// RULE3 - read phase sends count sixteen, then up to sixteen pointer bytes
// RULE4 - master acks count and bytes, then ends with STOP
// RULE5 - early STOP or master NACK stops device transmission
// RULE6 - block read starts at the pointer left by earlier transactions
// RULE7 - pointer advances after each byte read unless at a boundary
// RULE8 - busy or disallowed address byte is NACKed, pointer unchanged
// RULE9 - master sends STOP after a NACKed command byte
// RULE10 - register bank pointers 00h..2Fh accepted, others NACKed
// RULE11 - block write in register bank sticks at 2Fh
// RULE12 - configuration EEPROM pointers 80h..9Fh accepted
// RULE13 - block write in configuration EEPROM sticks at 9Fh
// RULE14 - user EEPROM pointers 40h..7Fh accepted for block read and write
// RULE15 - pointer moves from 7Fh straight on to 80h
// RULE16 - outputs forced asserted low once supply passes first level
// RULE17 - above lockout level copy EEPROM to latches within 2.5 ms
// RULE18 - above lockout level outputs follow their programmed conditions
// RULE19 - every transaction NACKed until the copy has finished; the code still ACKs the slave address byte and NACKs only the command byte
// RULE20 - configuration writes apply under 5 us, thresholds about 150 us
// RULE21 - EEPROM writes leave latches alone until reboot or power cycle
// RULE22 - send byte C4h reboots and repeats the configuration copy
// RULE23 - allowed send byte value loads the pointer
// RULE24 - block read at a stuck boundary repeats that boundary byte
`timescale 1ns/1ps
`include "smbus_pointer_map.vh"
module smbus_pointer_block_read #(
	parameter COPY_CYCLES = `COPY_CYCLES
) (
	input  wire       core_clk,
	input  wire       rstn,
	input  wire       sclIn,
	input  wire       sdaIn,
	output wire       sdaOut,
	output reg        sdaOe,
	input  wire       addrSelect,
	input  wire       supplyAboveOn,
	input  wire       supplyAboveLockout,
	input  wire [2:0] outCondition,
	output reg  [2:0] progOutN,
	output reg  [7:0] memAddr,
	input  wire [7:0] memRdata,
	output reg        memWrite,
	output reg  [7:0] memWdata,
	input  wire       eepromBusy,
	output reg        latchWrite,
	output reg  [4:0] latchAddr,
	output reg  [7:0] latchData,
	output reg        latchThreshold,
	output wire       copyDone
);
	localparam S_IDLE = 3'd0, S_ADDR = 3'd1, S_CMD = 3'd2, S_WDATA = 3'd3;
	localparam S_TX = 3'd4, S_RXACK = 3'd5, S_IGNORE = 3'd6;
	localparam P_OFF = 2'd0, P_WAIT = 2'd1, P_COPY = 2'd2, P_RUN = 2'd3;
	localparam [7:0] COUNT_BYTE = `BLOCK_COUNT; // byte count sent first in a block read

	// address is allowed in one of the three regions
	function allowed;
		input [7:0] a;
		begin
			allowed = (a <= `REG_LAST) || (a >= `USER_FIRST && a <= `CFG_LAST);
		end
	endfunction
	// next pointer after a byte, sticking at the register and configuration region ends (2Fh, 9Fh)
	function [7:0] advance;
		input [7:0] a;
		begin
			if (a == `REG_LAST || a == `CFG_LAST)
				advance = a;
			else
				advance = a + 8'h01;
		end
	endfunction

	reg [1:0] sclSync_q, sdaSync_q;
	reg       sclOld_q, sdaOld_q;
	reg [2:0] state_q;
	reg [3:0] bitCnt_q;
	reg [7:0] shift_q;
	reg [7:0] pointer_q;
	reg [4:0] sent_q;
	reg       readMode_q;
	reg       ackPend_q;
	reg       ackOk_q;
	reg       firstByte_q;
	reg [1:0] pState_q;
	reg [21:0] copyCnt_q;
	reg [5:0]  copyIdx_q;
	reg        rebootReq_q;
	reg [7:0]  txByte_q;
	reg        fetch_q;
	wire sclRise, sclFall, startSeen, stopSeen, scl, sda;
	wire busy;
	wire [7:0] fifoData;
	wire fifoValid, fifoLoad, popNow;

	// two-flop synchronisers for the serial pins
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sclSync_q <= 2'b11;
			sdaSync_q <= 2'b11;
			sclOld_q  <= 1'b1;
			sdaOld_q  <= 1'b1;
		end else begin
			sclSync_q <= {sclSync_q[0], sclIn};
			sdaSync_q <= {sdaSync_q[0], sdaIn};
			sclOld_q  <= sclSync_q[1];
			sdaOld_q  <= sdaSync_q[1];
		end
	end
	assign scl       = sclSync_q[1];
	assign sda       = sdaSync_q[1];
	assign sclRise   = scl && !sclOld_q;
	assign sclFall   = !scl && sclOld_q;
	assign startSeen = scl && sclOld_q && !sda && sdaOld_q;
	assign stopSeen  = scl && sclOld_q && sda && !sdaOld_q;
	assign busy      = (pState_q != P_RUN) || eepromBusy; // see RULE19
	assign copyDone  = (pState_q == P_RUN);
	assign sdaOut    = 1'b0;

	// read bytes are fetched after each ack and popped when the next byte starts
	assign fifoLoad = (state_q == S_TX || state_q == S_RXACK) && readMode_q;
	assign popNow   = (state_q == S_RXACK) && sclFall && (sent_q != 5'd0) && fifoValid;
	byte_fifo #(.WIDTH(8), .DEPTH(8), .AW(3)) txQueue (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clear    (!fifoLoad),
		.inData   (memRdata),
		.inValid  (fetch_q),
		.inReady  (),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (popNow)
	);

	// serial protocol engine
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q     <= S_IDLE;
			bitCnt_q    <= 4'd0;
			shift_q     <= 8'h00;
			pointer_q   <= 8'h00;
			sent_q      <= 5'd0;
			readMode_q  <= 1'b0;
			ackPend_q   <= 1'b0;
			ackOk_q     <= 1'b0;
			firstByte_q <= 1'b0;
			sdaOe       <= 1'b0;
			memWrite    <= 1'b0;
			memWdata    <= 8'h00;
			rebootReq_q <= 1'b0;
			txByte_q    <= 8'h00;
			fetch_q     <= 1'b0;
		end else begin
			memWrite    <= 1'b0;
			rebootReq_q <= 1'b0;
			fetch_q     <= 1'b0;
			// the write strobe carries the old pointer, so advance one cycle later
			if (memWrite)
				pointer_q <= advance(pointer_q); // see RULE11, RULE13
			if (stopSeen) begin
				state_q    <= S_IDLE; // see RULE5
				readMode_q <= 1'b0;
				sdaOe      <= 1'b0;
			end else if (startSeen) begin
				state_q  <= S_ADDR;
				bitCnt_q <= 4'd0;
				sdaOe    <= 1'b0;
			end else begin
				case (state_q)
				S_ADDR, S_CMD, S_WDATA: begin
					if (sclRise && bitCnt_q < 4'd8) begin
						shift_q  <= {shift_q[6:0], sda};
						bitCnt_q <= bitCnt_q + 4'd1;
					end else if (sclFall && bitCnt_q == 4'd8 && !ackPend_q) begin
						ackPend_q <= 1'b1;
						if (state_q == S_ADDR) begin
							ackOk_q <= (shift_q[7:4] == `SLAVE_ADDR_HI) && (shift_q[2] == addrSelect);
							sdaOe   <= (shift_q[7:4] == `SLAVE_ADDR_HI) && (shift_q[2] == addrSelect);
						end else if (state_q == S_CMD) begin
							ackOk_q <= !busy && (shift_q == `CMD_BLOCK_READ ||
								shift_q == `CMD_BLOCK_WRITE || shift_q == `CMD_REBOOT ||
								allowed(shift_q)); // see RULE8
							sdaOe   <= !busy && (shift_q == `CMD_BLOCK_READ ||
								shift_q == `CMD_BLOCK_WRITE || shift_q == `CMD_REBOOT ||
								allowed(shift_q));
							if (!busy && shift_q == `CMD_REBOOT)
								rebootReq_q <= 1'b1; // see RULE22
							else if (!busy && allowed(shift_q))
								pointer_q <= shift_q; // see RULE23, RULE10, RULE12, RULE14
						end else begin
							ackOk_q <= 1'b1;
							sdaOe   <= 1'b1;
							if (!firstByte_q) begin
								memWrite <= (pointer_q != `REG_LAST); // see RULE11
								memWdata <= shift_q;
							end
						end
					end else if (sclFall && ackPend_q) begin
						ackPend_q   <= 1'b0;
						sdaOe       <= 1'b0;
						bitCnt_q    <= 4'd0;
						firstByte_q <= 1'b0;
						if (!ackOk_q) begin
							state_q <= S_IGNORE; // see RULE9
						end else if (state_q == S_ADDR && shift_q[0]) begin
							state_q    <= readMode_q ? S_TX : S_IGNORE; // see RULE2
							txByte_q   <= `BLOCK_COUNT; // see RULE3
							sent_q     <= 5'd0;
							sdaOe      <= !COUNT_BYTE[7];
						end else if (state_q == S_ADDR) begin
							state_q    <= S_CMD;
							readMode_q <= 1'b0;
						end else if (state_q == S_CMD && shift_q == `CMD_BLOCK_READ) begin
							readMode_q <= 1'b1; // see RULE1, RULE6
							state_q    <= S_IGNORE;
						end else if (state_q == S_CMD && shift_q == `CMD_BLOCK_WRITE) begin
							state_q     <= S_WDATA;
							firstByte_q <= 1'b1;
						end else if (state_q == S_CMD) begin
							state_q <= S_IGNORE;
						end
					end
				end
				S_TX: begin
					if (sclFall && bitCnt_q < 4'd7) begin
						bitCnt_q <= bitCnt_q + 4'd1;
						sdaOe    <= !txByte_q[3'd6 - bitCnt_q[2:0]];
					end else if (sclFall) begin
						sdaOe   <= 1'b0;
						state_q <= S_RXACK;
					end
				end
				S_RXACK: begin
					if (sclRise) begin
						// every data byte read moves the pointer, acked or not
						if (sent_q != 5'd0)
							pointer_q <= advance(pointer_q); // see RULE7, RULE15, RULE24
						if (sda || sent_q == `BLOCK_COUNT) begin
							state_q    <= S_IGNORE; // see RULE5, RULE4
							readMode_q <= 1'b0;
						end else begin
							sent_q  <= sent_q + 5'd1;
							fetch_q <= 1'b1;
						end
					end else if (popNow) begin
						txByte_q <= fifoData;
						bitCnt_q <= 4'd0;
						state_q  <= S_TX;
						sdaOe    <= !fifoData[7];
					end
				end
				S_IGNORE: begin
					sdaOe <= 1'b0;
				end
				default: begin
					state_q <= S_IDLE;
				end
				endcase
			end
		end
	end

	// power-up and reboot copy sequencer
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pState_q   <= P_OFF;
			copyCnt_q  <= 22'd0;
			copyIdx_q  <= 6'd0;
			latchWrite <= 1'b0;
			latchAddr  <= 5'd0;
			latchData  <= 8'h00;
			progOutN   <= 3'b111;
		end else begin
			latchWrite <= 1'b0;
			case (pState_q)
			P_OFF: begin
				progOutN <= supplyAboveOn ? 3'b000 : 3'b111; // see RULE16
				if (supplyAboveLockout)
					pState_q <= P_COPY;
				copyIdx_q <= 6'd0;
				copyCnt_q <= 22'd0;
			end
			P_COPY: begin
				progOutN   <= ~outCondition; // see RULE18
				copyCnt_q  <= copyCnt_q + 22'd1;
				latchWrite <= !copyIdx_q[5]; // see RULE17, RULE21
				latchAddr  <= copyIdx_q[4:0];
				latchData  <= memRdata;
				copyIdx_q  <= copyIdx_q + 6'd1;
				if (copyIdx_q == 6'd32 || copyCnt_q == COPY_CYCLES[21:0] - 22'd1)
					pState_q <= P_RUN;
			end
			P_RUN: begin
				progOutN <= ~outCondition;
				if (!supplyAboveLockout)
					pState_q <= P_OFF;
				else if (rebootReq_q) begin
					pState_q  <= P_COPY;
					copyIdx_q <= 6'd0;
					copyCnt_q <= 22'd0;
				end
			end
			default: pState_q <= P_OFF;
			endcase
		end
	end

	// memory address: copy walk or pointer; thresholds flagged for slow update
	always @* begin
		memAddr        = (pState_q == P_COPY) ? (`CFG_FIRST + {2'b00, copyIdx_q}) : pointer_q;
		latchThreshold = latchWrite && (latchAddr < 5'd12); // see RULE20
	end
endmodule // smbus_pointer_block_read

/* include/smbus_pointer_map.vh */
/*
 * Address map, command codes and timing counts for the serial pointer block.
 * Assumes a 10 MHz core clock; included by the design file by bare name.
 */
`ifndef SMBUS_POINTER_MAP_VH
`define SMBUS_POINTER_MAP_VH
`define CMD_BLOCK_WRITE   8'hC0
`define CMD_BLOCK_READ    8'hC1
`define CMD_REBOOT        8'hC4
`define REG_FIRST         8'h00
`define REG_LAST          8'h2F
`define USER_FIRST        8'h40
`define USER_LAST         8'h7F
`define CFG_FIRST         8'h80
`define CFG_LAST          8'h9F
`define CFG_DEPTH         32
`define BLOCK_COUNT       8'h10
`define SLAVE_ADDR_HI     4'hA
`define CLK_KHZ           10000
`define COPY_MAX_US       2500
`define COPY_CYCLES       ((`COPY_MAX_US * `CLK_KHZ) / 1000)
`define UPDATE_MAX_NS     5000
`define UPDATE_CYCLES     ((`UPDATE_MAX_NS * `CLK_KHZ) / 1000000)
`define THRESH_US         150
`define THRESH_CYCLES     ((`THRESH_US * `CLK_KHZ) / 1000)
`endif

/* hw/byte_fifo.v */
/*
 * Small synchronous FIFO, flip-flop storage, valid/ready on both sides.
 * Assumes one clock and active-low asynchronous reset.
 */
`timescale 1ns/1ps
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             core_clk,
	input  wire             rstn,
	input  wire             clear,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr_q;
	reg [AW-1:0]    rdPtr_q;
	reg [AW:0]      count_q;
	wire            push;
	wire            pop;

	// honest full and empty flags
	assign inReady  = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr_q];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// storage written by index
	always @(posedge core_clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	// pointers and fill level
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else if (clear) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
			end
			count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // byte_fifo

/* sim/smbus_master_model.sv */
/* serial bus master model: start, stop, byte write and byte read.
   assumes the bench resolves the open-drain data line with a pull-up */
`timescale 1ns/1ps
module smbus_master_model (
	input  wire core_clk,
	input  wire sdaBus,
	output reg  scl,
	output reg  sdaLow
);
	// clock stands high and data is released between frames
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one 800 ns bit slot: 500 ns low, 300 ns high, sampled mid-high
	task automatic bitx(input logic b, output logic s);
		scl <= 1'b0;
		cyc(2);
		sdaLow <= ~b;
		cyc(3);
		scl <= 1'b1;
		cyc(1);
		@(negedge core_clk);
		s = sdaBus;
		cyc(2);
	endtask
	// start or repeated start
	task automatic start;
		scl <= 1'b0;
		cyc(2);
		sdaLow <= 1'b0;
		cyc(3);
		scl <= 1'b1;
		cyc(3);
		sdaLow <= 1'b1;
		cyc(3);
	endtask
	task automatic stop;
		scl <= 1'b0;
		cyc(2);
		sdaLow <= 1'b1;
		cyc(3);
		scl <= 1'b1;
		cyc(3);
		sdaLow <= 1'b0;
		cyc(3);
	endtask
	// msb first, then the slave answer in the ninth slot
	task automatic wr(input logic [7:0] d, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], s);
		bitx(1'b1, s);
		a = ~s;
	endtask
	task automatic rd(input logic ackIt, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, s);
			d[i] = s;
		end
		bitx(~ackIt, s);
	endtask
endmodule // smbus_master_model

/* sim/smbus_pointer_block_read_props.sv */
/* checker for the serial pointer block, bound to its top module.
   assumes a single core clock domain with active-low reset */
`timescale 1ns/1ps
module smbus_pointer_block_read_props #(
	parameter COPY_CYCLES = 25000
) (
	input wire       core_clk,
	input wire       rstn,
	input wire       sclIn,
	input wire       sdaIn,
	input wire       sdaOe,
	input wire       supplyAboveOn,
	input wire       supplyAboveLockout,
	input wire [2:0] outCondition,
	input wire [2:0] progOutN,
	input wire [7:0] memAddr,
	input wire       memWrite,
	input wire       latchWrite,
	input wire [4:0] latchAddr,
	input wire       latchThreshold,
	input wire       copyDone
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// cycles waited for the copy while the supply is good
	reg [15:0] waitQ;
	always @(posedge core_clk or negedge rstn)
		if (!rstn)
			waitQ <= 16'h0000;
		else
			waitQ <= (copyDone || !supplyAboveLockout) ? 16'h0000 : waitQ + 16'h0001;
	a_copy_bound: assert property (waitQ <= COPY_CYCLES)
		else $error("configuration copy too slow");
	a_forced_low: assert property (rstn && !copyDone && supplyAboveOn && !supplyAboveLockout
		##1 !supplyAboveLockout
		|-> progOutN == 3'b000) else $error("outputs not forced low");
	a_cond_follow: assert property ((copyDone && supplyAboveLockout && $stable(outCondition))[*3]
		|-> progOutN == ~outCondition) else $error("outputs ignore conditions");
	a_latch_copy: assert property (latchWrite |-> !copyDone)
		else $error("latch written outside a copy");
	a_thresh_map: assert property (latchWrite |-> latchThreshold == (latchAddr < 5'd12))
		else $error("threshold flag wrong");
	a_write_range: assert property (memWrite |-> copyDone && (memAddr < 8'h2F
		|| memAddr inside {[8'h40:8'h9F]})) else $error("write outside map");
	a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("data changed while clock high");
	a_stop_release: assert property (sclIn && $rose(sdaIn) |-> ##[1:8] !sdaOe)
		else $error("data held after stop");
endmodule // smbus_pointer_block_read_props
bind smbus_pointer_block_read smbus_pointer_block_read_props #(.COPY_CYCLES(COPY_CYCLES)) props (
	.core_clk(core_clk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
	.supplyAboveOn(supplyAboveOn), .supplyAboveLockout(supplyAboveLockout),
	.outCondition(outCondition), .progOutN(progOutN), .memAddr(memAddr), .memWrite(memWrite),
	.latchWrite(latchWrite), .latchAddr(latchAddr), .latchThreshold(latchThreshold),
	.copyDone(copyDone));

/* sim/smbus_pointer_block_read_bench.sv */
/* self-checking bench: copy, pointer loads, block reads, refusals, block write, reboot.
   assumes the master model and checker are compiled first */
`timescale 1ns/1ps
module smbus_pointer_block_read_bench;
	logic       core_clk, rstn, addrSelect, supplyAboveOn, supplyAboveLockout, eepromBusy;
	logic       sdaOut, sdaOe, memWrite, latchWrite, latchThreshold, copyDone, scl, sdaLow, ack;
	logic [2:0] outCondition, progOutN;
	logic [4:0] latchAddr;
	logic [7:0] memAddr, memWdata, latchData, mem [0:255];
	logic [31:0] bw;
	logic [7:0] keep;
	logic [7:0] starts [4] = '{8'h28, 8'h78, 8'h98, 8'h40};
	logic [7:0] bad [4] = '{8'h30, 8'h3F, 8'hA0, 8'hFF};
	wire        sdaBus = !(sdaLow || (sdaOe && !sdaOut));
	integer     n_fail = 0, tests_run = 0, seed = 32'h8b9c, nLatch = 0, ptr, i;
	smbus_pointer_block_read #(.COPY_CYCLES(400)) dut (.core_clk(core_clk), .rstn(rstn),
		.sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelect(addrSelect),
		.supplyAboveOn(supplyAboveOn), .supplyAboveLockout(supplyAboveLockout),
		.outCondition(outCondition), .progOutN(progOutN), .memAddr(memAddr),
		.memRdata(mem[memAddr]), .memWrite(memWrite), .memWdata(memWdata),
		.eepromBusy(eepromBusy), .latchWrite(latchWrite), .latchAddr(latchAddr),
		.latchData(latchData), .latchThreshold(latchThreshold), .copyDone(copyDone));
	smbus_master_model bm (.core_clk(core_clk), .sdaBus(sdaBus), .scl(scl), .sdaLow(sdaLow));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// memory side: writes land at the pointer, every latch load must match memory
	always @(posedge core_clk) begin
		if (memWrite)
			mem[memAddr] <= memWdata;
		if (rstn && latchWrite) begin
			nLatch++;
			chk(latchData, mem[{3'b100, latchAddr}]);
		end
	end
	task automatic head(input logic [7:0] cmd, output logic a);
		bm.start;
		bm.wr({4'hA, 1'b0, addrSelect, 2'b10}, a);
		if (a)
			bm.wr(cmd, a);
	endtask
	task automatic sendp(input logic [7:0] p, input logic e);
		logic a;
		head(p, a);
		bm.stop;
		chk({7'h00, a}, {7'h00, e});
	endtask
	task automatic waitDone;
		for (int w = 0; w < 1000 && copyDone !== 1'b1; w++)
			@(posedge core_clk);
		chk({7'h00, copyDone}, 8'h01);
	endtask
	// block read of n data bytes against the pointer model
	task automatic bread(input integer n);
		logic a;
		logic [7:0] v;
		head(8'hC1, a);
		chk({7'h00, a}, 8'h01);
		bm.start;
		bm.wr({4'hA, 1'b0, addrSelect, 2'b11}, a);
		bm.rd(1'b1, v);
		chk(v, 8'h10);
		for (int k = 0; k < n; k++) begin
			bm.rd(k < n - 1, v);
			chk(v, mem[ptr]);
			ptr = (ptr == 8'h2F || ptr == 8'h9F) ? ptr : ptr + 1;
		end
		if (n < 16) begin
			bm.rd(1'b0, v);
			chk(v, 8'hFF);
		end
		bm.stop;
	endtask
	initial begin
		rstn = 1'b0;
		supplyAboveOn = 1'b1;
		supplyAboveLockout = 1'b0;
		eepromBusy = 1'b0;
		addrSelect = 1'b0;
		outCondition = 3'b000;
		for (i = 0; i < 256; i++)
			mem[i] = $random(seed);
		starts[3] = {2'b01, 6'($random(seed))};
		@(posedge core_clk);
		addrSelect <= $random(seed);
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		sendp(8'h40, 1'b0);
		supplyAboveLockout <= 1'b1;
		waitDone;
		chk(nLatch[7:0], 8'h20);
		foreach (starts[j]) begin
			outCondition <= $random(seed);
			ptr = starts[j];
			sendp(starts[j], 1'b1);
			bread(16);
		end
		ptr = 8'h50;
		sendp(8'h50, 1'b1);
		foreach (bad[j])
			sendp(bad[j], 1'b0);
		bread(3);
		eepromBusy <= 1'b1;
		head(8'hC1, ack);
		bm.stop;
		chk({7'h00, ack}, 8'h00);
		eepromBusy <= 1'b0;
		bread(2);
		sendp(8'h9E, 1'b1);
		i = nLatch;
		bw = $random(seed);
		head(8'hC0, ack);
		bm.wr(8'h04, ack);
		for (int k = 0; k < 4; k++)
			bm.wr(bw[31 - 8 * k -: 8], ack);
		bm.stop;
		chk(mem[8'h9E], bw[31:24]);
		chk(mem[8'h9F], bw[7:0]);
		chk(8'(nLatch - i), 8'h00);
		sendp(8'h2E, 1'b1);
		keep = mem[8'h2F];
		head(8'hC0, ack);
		bm.wr(8'h02, ack);
		bm.wr(bw[15:8], ack);
		bm.wr(bw[23:16], ack);
		bm.stop;
		chk(mem[8'h2E], bw[15:8]);
		chk(mem[8'h2F], keep);
		i = nLatch;
		sendp(8'hC4, 1'b1);
		for (int k = 0; k < 1000 && nLatch - i < 32; k++)
			@(posedge core_clk);
		waitDone;
		chk(8'(nLatch - i), 8'h20);
		report_and_stop;
	end
	// cut a hang short well beyond the expected run length
	initial begin
		repeat (60000) @(posedge core_clk);
		n_fail++;
		report_and_stop;
	end
endmodule // smbus_pointer_block_read_bench
